// >>> rtl/pcmcs_top.sv
// Behaviour
// - FIFO RAMs stay in standby while the standby release bit is zero.
// - The echo bit reads back its written value after two bit clocks.
// - With sign extension on, the received channel MSB fills higher bits.
// - Receive full flag is high when the receive FIFO is full.
// - Transmit empty flag is high when the transmit FIFO is empty; resets high.
// - Receive has-sample flag is high while the receive FIFO holds data.
// - Transmit has-space flag is high unless the FIFO is full; resets high.
// - Receive needs-read is high while fill is at or above its threshold.
// - Transmit needs-write is high while fill is below its threshold; resets high.
// - FIFO under or overflow latches a fault flag; writing one clears it.
// - Frame-aligned flags show whole frames held, counting the partial frame.
// - With DMA allowed, requests follow transmit and receive levels versus limits.
// - Receive level select picks one sample, two partial levels, or full.
// - Transmit level select picks empty, two partial levels, or full but one.
// - Receive flush empties the FIFO within two bit clocks; reads zero.
// - Transmit flush empties the FIFO within two bit clocks; reads zero.
// - Clearing transmit run stops at once if idle, else at frame end.
// - Setting transmit run starts at the next frame start, channel one first.
// - The frame counter runs while the enable bit and transmit or receive run are set.
// - Reserved bits are written as zero and read here as zero.
// - Receive run stops at frame end and starts at the next frame start.
// - With the enable bit clear, most logic is held off.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
module pcmcs_top #(
	parameter int DEPTH = 64,
	parameter int AW    = 8
) (
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic [AW-1:0]             s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [AW-1:0]             s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      pcm_clk,
	input  wire pcmcs_pkg::pcmcs_fifo_stat_t fifo_stat,
	input  wire pcmcs_pkg::pcmcs_frame_evt_t frame_evt,
	input  wire logic [31:0]               rx_raw_data,
	input  wire logic                      rx_raw_valid,
	input  wire logic [4:0]                channel_width,
	input  wire logic [pcmcs_pkg::LVL_W-1:0] tx_dma_level,
	input  wire logic [pcmcs_pkg::LVL_W-1:0] rx_dma_level,
	output pcmcs_pkg::pcmcs_ctrl_t         ctrl,
	output logic [31:0]                    rx_data,
	output logic                           rx_data_valid
);
	localparam int LW = pcmcs_pkg::LVL_W;

	if (DEPTH < 4 || DEPTH % 4 != 0 || DEPTH > 2**LW - 1 || AW < 3 || AW > 32) begin : g_bad_cfg
		$error("pcmcs_top: DEPTH or AW out of range");
	end

	function automatic logic addr_hit(input logic [AW-1:0] a);
		return a[AW-1:2] == pcmcs_pkg::CSW_OFFSET[AW-1:2];
	endfunction

	function automatic logic [31:0] byte_mask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// Thresholds: 1, quarter, three quarters, full
	function automatic logic [LW-1:0] rx_thr(input logic [1:0] sel);
		unique case (sel)
			2'h0: return LW'(1);
			2'h1: return LW'(DEPTH / 4);
			2'h2: return LW'(DEPTH * 3 / 4);
			2'h3: return LW'(DEPTH);
		endcase
	endfunction

	// Flag holds while fill is below: 1 (empty), quarter, three quarters, full less one
	function automatic logic [LW-1:0] tx_thr(input logic [1:0] sel);
		unique case (sel)
			2'h0: return LW'(1);
			2'h1: return LW'(DEPTH / 4);
			2'h2: return LW'(DEPTH * 3 / 4);
			2'h3: return LW'(DEPTH - 1);
		endcase
	endfunction

	function automatic logic [31:0] sign_fill(input logic [31:0] d, input logic [4:0] msb);
		logic [31:0] r;
		r = d;
		for (int i = 0; i < 32; i++) begin
			if (i > int'(msb)) begin
				r[i] = d[msb];
			end
		end
		return r;
	endfunction

	logic        rst_meta_q;
	logic        rst_sync_n;
	logic        pclk_s1_q;
	logic        pclk_s2_q;
	logic        pclk_s3_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;
	logic [AW-1:0] awaddr_q;
	logic [AW-1:0] araddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [31:0] cfg_q;
	logic [31:0] stat_q;
	logic [31:0] stat_d;
	logic [1:0]  fault_q;
	logic        echo_s1_q;
	logic        echo_q;
	logic [1:0]  flush_q;
	logic [1:0]  flush_cnt_q [2];
	pcmcs_pkg::pcmcs_ctrl_t ctrl_q;
	pcmcs_pkg::pcmcs_ctrl_t ctrl_d;
	logic [31:0] rxd_q;
	logic        rxv_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Bit clock is slow against sys_clk, so sampling finds every edge
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pclk_s1_q <= 1'b0;
			pclk_s2_q <= 1'b0;
			pclk_s3_q <= 1'b0;
		end else begin
			pclk_s1_q <= pcm_clk;
			pclk_s2_q <= pclk_s1_q;
			pclk_s3_q <= pclk_s2_q;
		end
	end

	wire pcm_rise = pclk_s2_q & ~pclk_s3_q;

	// AXI4-Lite slave: one write and one read in flight
	wire aw_take = s_axi_awvalid & awready_q;
	wire w_take  = s_axi_wvalid & wready_q;
	wire ar_take = s_axi_arvalid & arready_q;
	wire wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
	wire rd_fire = ~arready_q & ~rvalid_q;
	wire wr_hit  = wr_fire & addr_hit(awaddr_q);
	wire b_done  = bvalid_q & s_axi_bready;
	wire r_done  = rvalid_q & s_axi_rready;
	wire [31:0] wm  = byte_mask(wstrb_q);
	wire [31:0] wsel = wdata_q & wm;

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= pcmcs_pkg::RESP_OKAY;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
		end else begin
			if (aw_take) begin
				awready_q <= 1'b0;
				awaddr_q  <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_q <= 1'b0;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? pcmcs_pkg::RESP_OKAY : pcmcs_pkg::RESP_DECERR;
			end
			if (b_done) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// Reserved and write-only bits read as zero
	wire [31:0] rd_word = (cfg_q & pcmcs_pkg::RW_MASK & ~pcmcs_pkg::ECHO_MASK)
		| ({32{echo_q}} & pcmcs_pkg::ECHO_MASK)
		| stat_q
		| ({32{fault_q[1]}} & pcmcs_pkg::RX_FAULT_MASK)
		| ({32{fault_q[0]}} & pcmcs_pkg::TX_FAULT_MASK);

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= pcmcs_pkg::RESP_OKAY;
			rdata_q   <= '0;
			araddr_q  <= '0;
		end else begin
			if (ar_take) begin
				arready_q <= 1'b0;
				araddr_q  <= s_axi_araddr;
			end
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rresp_q  <= addr_hit(araddr_q) ? pcmcs_pkg::RESP_OKAY : pcmcs_pkg::RESP_DECERR;
				rdata_q  <= addr_hit(araddr_q) ? rd_word : 32'h0000_0000;
			end
			if (r_done) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// Only the writable fields are stored; reserved write data is dropped
	wire [31:0] cfg_wm = wm & pcmcs_pkg::RW_MASK;
	wire [31:0] cfg_d  = wr_hit ? ((cfg_q & ~cfg_wm) | (wdata_q & cfg_wm)) : cfg_q;

	wire en        = cfg_q[pcmcs_pkg::BIT_ENABLE];
	wire tx_run    = cfg_q[pcmcs_pkg::BIT_TX_RUN];
	wire rx_run    = cfg_q[pcmcs_pkg::BIT_RX_RUN];
	wire dma_allow = cfg_q[pcmcs_pkg::BIT_DMA_ALLOW];
	wire sign_ext  = cfg_q[pcmcs_pkg::BIT_SIGN_EXT];
	wire [1:0] rx_sel = cfg_q[pcmcs_pkg::BIT_RX_LVL_LO +: 2];
	wire [1:0] tx_sel = cfg_q[pcmcs_pkg::BIT_TX_LVL_LO +: 2];

	// Set beats clear when a fault arrives with the clearing write
	wire [1:0] fault_clr = {2{wr_hit}}
		& {wsel[pcmcs_pkg::BIT_RX_FAULT], wsel[pcmcs_pkg::BIT_TX_FAULT]};
	wire [1:0] fault_evt = {fifo_stat.rx_fault_evt, fifo_stat.tx_fault_evt};
	wire [1:0] fault_d   = fault_evt | (fault_q & ~fault_clr);

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cfg_q   <= '0;
			fault_q <= '0;
			stat_q  <= pcmcs_pkg::CSW_RESET & pcmcs_pkg::STAT_MASK;
		end else begin
			cfg_q   <= cfg_d;
			fault_q <= fault_d;
			stat_q  <= stat_d;
		end
	end

	// Echo moves on bit-clock edges only, two stages deep
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			echo_s1_q <= 1'b0;
			echo_q    <= 1'b0;
		end else if (pcm_rise) begin
			echo_s1_q <= cfg_q[pcmcs_pkg::BIT_ECHO];
			echo_q    <= echo_s1_q;
		end
	end

	// Index 1 is receive, 0 is transmit; a new request restarts the count
	wire [1:0] flush_set = {2{wr_hit}}
		& {wsel[pcmcs_pkg::BIT_RX_FLUSH], wsel[pcmcs_pkg::BIT_TX_FLUSH]};

	wire [1:0] flush_last;

	for (genvar g = 0; g < 2; g++) begin : g_flush
		assign flush_last[g] = flush_q[g] & pcm_rise
			& (flush_cnt_q[g] == pcmcs_pkg::FLUSH_BITCLKS - 2'h1);
	end

	// One process owns both flush bits so each flop has a single driver
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flush_q        <= 2'h0;
			flush_cnt_q[0] <= 2'h0;
			flush_cnt_q[1] <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (flush_set[i]) begin
					flush_q[i]     <= 1'b1;
					flush_cnt_q[i] <= 2'h0;
				end else if (flush_last[i]) begin
					flush_q[i] <= 1'b0;
				end else if (flush_q[i] && pcm_rise) begin
					flush_cnt_q[i] <= flush_cnt_q[i] + 2'h1;
				end
			end
		end
	end

	// Levels and flags; assumes two channels to a frame
	wire [LW-1:0] rx_lvl = fifo_stat.rx_level;
	wire [LW-1:0] tx_lvl = fifo_stat.tx_level;

	always_comb begin
		stat_d = 32'h0000_0000;
		stat_d[pcmcs_pkg::BIT_RX_FULL]    = rx_lvl >= LW'(DEPTH);
		stat_d[pcmcs_pkg::BIT_TX_EMPTY]   = tx_lvl == '0;
		stat_d[pcmcs_pkg::BIT_RX_HAS]     = rx_lvl != '0;
		stat_d[pcmcs_pkg::BIT_TX_SPACE]   = tx_lvl < LW'(DEPTH);
		stat_d[pcmcs_pkg::BIT_RX_NEEDS]   = rx_lvl >= rx_thr(rx_sel);
		stat_d[pcmcs_pkg::BIT_TX_NEEDS]   = tx_lvl < tx_thr(tx_sel);
		stat_d[pcmcs_pkg::BIT_RX_ALIGNED] = ~(rx_lvl[0] ^ frame_evt.rx_mid_frame);
		stat_d[pcmcs_pkg::BIT_TX_ALIGNED] = ~(tx_lvl[0] ^ frame_evt.tx_mid_frame);
	end

	// Run control: starts wait for a frame start so channel one leads
	wire tx_start = tx_run & frame_evt.frame_start & ~ctrl_q.tx_active;
	wire tx_stop  = ~tx_run & ctrl_q.tx_active & (frame_evt.tx_idle | frame_evt.frame_end);
	wire rx_start = rx_run & frame_evt.frame_start & ~ctrl_q.rx_active;
	wire rx_stop  = ~rx_run & ctrl_q.rx_active & frame_evt.frame_end;

	always_comb begin
		ctrl_d                 = ctrl_q;
		ctrl_d.enable          = en;
		ctrl_d.ram_standby     = ~cfg_q[pcmcs_pkg::BIT_STANDBY];
		ctrl_d.rx_flush        = flush_q[1];
		ctrl_d.tx_flush        = flush_q[0];
		ctrl_d.frame_count_run = en & (tx_run | rx_run);
		ctrl_d.tx_dreq         = en & dma_allow & (tx_lvl < tx_dma_level);
		ctrl_d.rx_dreq         = en & dma_allow & (rx_lvl > rx_dma_level);
		if (tx_start) begin
			ctrl_d.tx_active = 1'b1;
		end else if (tx_stop) begin
			ctrl_d.tx_active = 1'b0;
		end
		if (rx_start) begin
			ctrl_d.rx_active = 1'b1;
		end else if (rx_stop) begin
			ctrl_d.rx_active = 1'b0;
		end
		if (!en) begin
			ctrl_d.tx_active = 1'b0;
			ctrl_d.rx_active = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_q <= '{ram_standby: 1'b1, default: 1'b0};
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Receive data path is held while disabled
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rxd_q <= '0;
			rxv_q <= 1'b0;
		end else begin
			rxv_q <= rx_raw_valid & en;
			if (rx_raw_valid && en) begin
				rxd_q <= sign_ext ? sign_fill(rx_raw_data, channel_width) : rx_raw_data;
			end
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign ctrl          = ctrl_q;
	assign rx_data       = rxd_q;
	assign rx_data_valid = rxv_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_n);

	sequence s_wr_taken;
		~awready_q && ~wready_q && !bvalid_q;
	endsequence
	sequence s_wr_answer;
		bvalid_q && !awready_q && !wready_q;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && arready_q;
	endsequence

	chk_write_answer: assert property (s_wr_taken |=> s_wr_answer)
		else $error("write response missing");
	chk_read_answer: assert property (s_rd_taken |-> ##2 (rvalid_q && !arready_q))
		else $error("read response missing");
	chk_flush_reads0: assert property (rvalid_q |-> (rdata_q[4:3] == 2'h0 && rdata_q[12:10] == 3'h0))
		else $error("write-only or reserved bits read nonzero");
	chk_standby_rel: assert property (wr_hit && wsel[pcmcs_pkg::BIT_STANDBY] |-> ##2 !ctrl_q.ram_standby)
		else $error("standby not released");
	chk_echo_edge: assert property ($changed(echo_q) |-> $past(pcm_rise))
		else $error("echo moved without a bit clock");
	chk_flush_end: assert property ($fell(flush_q[1]) |-> $past(pcm_rise) && !$past(flush_set[1]))
		else $error("receive flush ended off a bit clock");
	chk_fault_sticky: assert property (fault_evt[1] |=> fault_q[1] ##1 (fault_q[1] || $past(fault_clr[1])))
		else $error("receive fault not latched");
	chk_full_flags: assert property (stat_q[pcmcs_pkg::BIT_RX_FULL] |-> stat_q[pcmcs_pkg::BIT_RX_HAS] && stat_q[pcmcs_pkg::BIT_RX_NEEDS])
		else $error("receive full without has-sample or needs-read");
	chk_empty_flags: assert property (stat_q[pcmcs_pkg::BIT_TX_EMPTY] |-> stat_q[pcmcs_pkg::BIT_TX_SPACE] && stat_q[pcmcs_pkg::BIT_TX_NEEDS])
		else $error("transmit empty without space or needs-write");
	chk_tx_start: assert property ($rose(ctrl_q.tx_active) |-> $past(frame_evt.frame_start && tx_run))
		else $error("transmit began off a frame start");
	chk_rx_stop: assert property ($fell(ctrl_q.rx_active) |-> $past(frame_evt.frame_end || !en))
		else $error("reception stopped mid frame");
	chk_dreq_gate: assert property (!dma_allow |=> !ctrl_q.tx_dreq && !ctrl_q.rx_dreq)
		else $error("DMA request while not allowed");
	chk_sign_ext: assert property (rx_raw_valid && en && sign_ext |=> rxd_q[31] == $past(rx_raw_data[channel_width]))
		else $error("sign extension wrong");
endmodule

// >>> rtl/pcmcs_pkg.sv
package pcmcs_pkg;
	localparam int          LVL_W          = 7;
	localparam logic [31:0] CSW_OFFSET     = 32'h0000_0000;
	localparam int          BIT_ENABLE     = 0;
	localparam int          BIT_RX_RUN     = 1;
	localparam int          BIT_TX_RUN     = 2;
	localparam int          BIT_TX_FLUSH   = 3;
	localparam int          BIT_RX_FLUSH   = 4;
	localparam int          BIT_TX_LVL_LO  = 5;
	localparam int          BIT_RX_LVL_LO  = 7;
	localparam int          BIT_DMA_ALLOW  = 9;
	localparam int          BIT_TX_ALIGNED = 13;
	localparam int          BIT_RX_ALIGNED = 14;
	localparam int          BIT_TX_FAULT   = 15;
	localparam int          BIT_RX_FAULT   = 16;
	localparam int          BIT_TX_NEEDS   = 17;
	localparam int          BIT_RX_NEEDS   = 18;
	localparam int          BIT_TX_SPACE   = 19;
	localparam int          BIT_RX_HAS     = 20;
	localparam int          BIT_TX_EMPTY   = 21;
	localparam int          BIT_RX_FULL    = 22;
	localparam int          BIT_SIGN_EXT   = 23;
	localparam int          BIT_ECHO       = 24;
	localparam int          BIT_STANDBY    = 25;
	localparam logic [31:0] RW_MASK        = 32'h0380_03e7;
	localparam logic [31:0] ECHO_MASK      = 32'h0100_0000;
	localparam logic [31:0] RX_FAULT_MASK  = 32'h0001_0000;
	localparam logic [31:0] TX_FAULT_MASK  = 32'h0000_8000;
	localparam logic [31:0] STAT_MASK      = 32'h007e_6000;
	localparam logic [31:0] CSW_RESET      = 32'h002a_0000;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_DECERR    = 2'h3;
	localparam logic [1:0]  ECHO_BITCLKS   = 2'h2;
	localparam logic [1:0]  FLUSH_BITCLKS  = 2'h2;

	typedef struct packed {
		logic [LVL_W-1:0] rx_level;
		logic [LVL_W-1:0] tx_level;
		logic             rx_fault_evt;
		logic             tx_fault_evt;
	} pcmcs_fifo_stat_t;

	typedef struct packed {
		logic frame_start;
		logic frame_end;
		logic tx_idle;
		logic rx_mid_frame;
		logic tx_mid_frame;
	} pcmcs_frame_evt_t;

	typedef struct packed {
		logic enable;
		logic ram_standby;
		logic rx_flush;
		logic tx_flush;
		logic tx_active;
		logic rx_active;
		logic frame_count_run;
		logic tx_dreq;
		logic rx_dreq;
	} pcmcs_ctrl_t;
endpackage

// >>> dv/pcmcs_far_model.sv
module pcmcs_far_model (
	input  wire logic                        sys_clk,
	input  wire logic                        clk_on,
	input  wire logic [6:0]                  rx_lvl,
	input  wire logic [6:0]                  tx_lvl,
	input  wire logic                        rx_bad,
	input  wire logic                        tx_bad,
	input  wire logic                        mid,
	input  wire logic                        idle,
	output logic                             pcm_clk,
	output pcmcs_pkg::pcmcs_fifo_stat_t      fifo_stat,
	output pcmcs_pkg::pcmcs_frame_evt_t      frame_evt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] sync_q = 3'h0;
	logic [3:0] bit_q = 4'h0;
	logic       rise;

	initial pcm_clk = 1'b0;
	// Bit clock stands still until the bench asks for traffic
	always #200 if (clk_on) pcm_clk = ~pcm_clk;

	always @(posedge sys_clk) begin
		sync_q <= {sync_q[1:0], pcm_clk};
		if (rise)
			bit_q <= bit_q + 4'h1;
	end

	assign rise      = sync_q[1] & ~sync_q[2];
	// Sixteen bit clocks to a frame; the bench decides when the transmitter is idle
	assign frame_evt = {rise && bit_q == 4'h0, rise && bit_q == 4'hf, idle, mid, mid};
	assign fifo_stat = {rx_lvl, tx_lvl, rx_bad, tx_bad};
endmodule

// >>> dv/pcmcs_top_tb.sv
module pcmcs_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int D = 64;
	logic        sys_clk = 0, rst_n = 0, clk_on = 0, mid = 0, rx_bad = 0, tx_bad = 0, idle = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rx_raw_data = 0, rx_data, s_axi_rdata, d, v, s0;
	logic        rx_raw_valid = 0, rx_data_valid, pcm_clk;
	logic [4:0]  channel_width = 0;
	logic [6:0]  tdl = 0, rdl = 0, rl = 0, tl = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          bad_count = 0, checks = 0, cyc = 0, n, cw, seed_val;
	logic [6:0]  rc [8] = '{0, 1, 15, 16, 47, 48, 63, 64};
	pcmcs_pkg::pcmcs_fifo_stat_t fifo_stat;
	pcmcs_pkg::pcmcs_frame_evt_t frame_evt;
	pcmcs_pkg::pcmcs_ctrl_t      ctrl;

	always #25 sys_clk = ~sys_clk;

	pcmcs_far_model i_far (.sys_clk(sys_clk), .clk_on(clk_on), .rx_lvl(rl), .tx_lvl(tl),
		.rx_bad(rx_bad), .tx_bad(tx_bad), .mid(mid), .idle(idle), .pcm_clk(pcm_clk),
		.fifo_stat(fifo_stat), .frame_evt(frame_evt));

	pcmcs_top #(.DEPTH(D), .AW(8)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready), .pcm_clk(pcm_clk),
		.fifo_stat(fifo_stat), .frame_evt(frame_evt), .rx_raw_data(rx_raw_data),
		.rx_raw_valid(rx_raw_valid), .channel_width(channel_width), .tx_dma_level(tdl),
		.rx_dma_level(rdl), .ctrl(ctrl), .rx_data(rx_data), .rx_data_valid(rx_data_valid));

	task give_verdict;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] dat);
		logic got;
		got = 0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got) begin
			@(posedge sys_clk);
			if (awvalid && s_axi_awready)
				awvalid <= 1'b0;
			if (wvalid && s_axi_wready)
				wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				got = 1;
				r = s_axi_bresp;
				bready <= 1'b0;
			end
		end
	endtask

	task rd(input logic [7:0] a);
		logic got;
		got = 0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(posedge sys_clk);
			if (arvalid && s_axi_arready)
				arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				got = 1;
				d = s_axi_rdata;
				r = s_axi_rresp;
				rready <= 1'b0;
			end
		end
	endtask

	task rdc(input logic [31:0] exp);
		rd(8'h00);
		chk(d, exp);
	endtask

	function automatic logic [31:0] stat(int rx, int tx, int rs, int ts, logic m);
		logic [31:0] s;
		int          rt;
		int          tt;
		rt = (rs == 0) ? 1 : (rs == 1) ? D / 4 : (rs == 2) ? 3 * D / 4 : D;
		tt = (ts == 0) ? 1 : (ts == 1) ? D / 4 : (ts == 2) ? 3 * D / 4 : D - 1;
		s = 32'h0000_0000;
		s[22] = (rx == D);
		s[21] = (tx == 0);
		s[20] = (rx != 0);
		s[19] = (tx != D);
		s[18] = (rx >= rt);
		s[17] = (tx < tt);
		s[14] = ((rx % 2) == m);
		s[13] = ((tx % 2) == m);
		return s;
	endfunction

	function automatic logic [31:0] sx(logic [31:0] x, int w, logic e);
		logic [31:0] o;
		o = x;
		if (e)
			for (int i = w + 1; i < 32; i++)
				o[i] = x[w];
		return o;
	endfunction

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict;
		end
	end

	task wait_evt(input logic at_end);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!(at_end ? frame_evt.frame_end : frame_evt.frame_start) && n < 400);
		repeat (2) @(posedge sys_clk);
	endtask

	initial begin
		seed_val = $urandom(32'hd56b0b75);
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(32'(ctrl), 32'h0000_0080);
		rdc(stat(0, 0, 0, 0, 1'b0));
		clk_on <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			v = $urandom & pcmcs_pkg::RW_MASK & ~pcmcs_pkg::ECHO_MASK & ~32'h0000_001f;
			v[8:7] = 2'(i % 4);
			v[6:5] = 2'((i + 1) % 4);
			rl <= (i < 8) ? rc[i] : 7'($urandom_range(D, 0));
			tl <= (i < 8) ? rc[7 - i] : 7'($urandom_range(D, 0));
			mid <= 1'($urandom);
			wr(8'h00, v | 32'hfc00_1c00);
			chk(32'(r), 32'(pcmcs_pkg::RESP_OKAY));
			rdc(v | stat(rl, tl, v[8:7], v[6:5], mid));
			chk(32'(ctrl.ram_standby), 32'(!v[25]));
		end
		s0 = v | stat(rl, tl, v[8:7], v[6:5], mid);
		rx_bad <= 1'b1;
		tx_bad <= 1'b1;
		@(posedge sys_clk);
		rx_bad <= 1'b0;
		tx_bad <= 1'b0;
		rdc(s0 | pcmcs_pkg::RX_FAULT_MASK | pcmcs_pkg::TX_FAULT_MASK);
		wr(8'h00, v | pcmcs_pkg::RX_FAULT_MASK);
		rdc(s0 | pcmcs_pkg::TX_FAULT_MASK);
		wr(8'h00, v | pcmcs_pkg::TX_FAULT_MASK);
		rdc(s0);
		s0 = stat(rl, tl, 0, 0, mid);
		// Release standby first and give it four bit clocks before any run bit
		wr(8'h00, 32'h0300_0001);
		rdc(32'h0200_0001 | s0);
		chk(32'(ctrl.enable), 32'h1);
		repeat (4) @(posedge pcm_clk);
		rdc(32'h0300_0001 | s0);
		wr(8'h00, 32'h0200_0019);
		n = 0;
		while (!(ctrl.tx_flush && ctrl.rx_flush) && n < 10) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(n < 10), 32'h1);
		n = 0;
		while ((ctrl.tx_flush || ctrl.rx_flush) && n < 60) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(n >= 6 && n < 60), 32'h1);
		rdc(32'h0200_0001 | s0);
		wr(8'h00, 32'h0200_0201);
		for (int i = 0; i < 8; i++) begin
			tdl <= 7'($urandom_range(D, 0));
			rdl <= 7'($urandom_range(D, 0));
			@(posedge sys_clk);
			tl <= (i == 0) ? tdl : 7'($urandom_range(D, 0));
			rl <= (i == 0) ? rdl : 7'($urandom_range(D, 0));
			repeat (4) @(posedge sys_clk);
			chk(32'(ctrl.tx_dreq), 32'(tl < tdl));
			chk(32'(ctrl.rx_dreq), 32'(rl > rdl));
		end
		for (int k = 0; k < 2; k++) begin
			wr(8'h00, k ? 32'h0200_0001 : 32'h0280_0001);
			for (int i = 0; i < 8; i++) begin
				cw = (i == 0) ? 31 : $urandom_range(31, 0);
				@(posedge sys_clk);
				rx_raw_data <= $urandom;
				channel_width <= 5'(cw);
				rx_raw_valid <= 1'b1;
				@(posedge sys_clk);
				rx_raw_valid <= 1'b0;
				@(posedge sys_clk);
				chk(32'(rx_data_valid), 32'h1);
				chk(rx_data, sx(rx_raw_data, cw, k == 0));
			end
		end
		wr(8'h00, 32'h0200_0005);
		@(posedge sys_clk);
		chk(32'(ctrl.frame_count_run), 32'h1);
		wait_evt(1'b0);
		chk(32'(ctrl.tx_active), 32'h1);
		wr(8'h00, 32'h0200_0003);
		chk(32'(ctrl.tx_active), 32'h1);
		wait_evt(1'b1);
		chk(32'(ctrl.tx_active), 32'h0);
		chk(32'(ctrl.rx_active), 32'h0);
		wait_evt(1'b0);
		chk(32'(ctrl.rx_active), 32'h1);
		// Idle transmitter: clearing the run bit must stop well before frame end
		wr(8'h00, 32'h0200_0007);
		wait_evt(1'b0);
		chk(32'(ctrl.tx_active), 32'h1);
		idle <= 1'b1;
		wr(8'h00, 32'h0200_0003);
		@(posedge sys_clk);
		chk(32'(ctrl.tx_active), 32'h0);
		idle <= 1'b0;
		wr(8'h00, 32'h0200_0002);
		@(posedge sys_clk);
		chk(32'({ctrl.enable, ctrl.rx_active, ctrl.frame_count_run}), 32'h0);
		wr(8'h04, 32'h0000_0001);
		chk(32'(r), 32'(pcmcs_pkg::RESP_DECERR));
		rd(8'hfc);
		chk({r, d[29:0]}, {pcmcs_pkg::RESP_DECERR, 30'h0});
		give_verdict;
	end
endmodule
